// ==== logic/itf_input_decoder.sv ====
// multi-function input terminal decoder with apb configuration
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "itf_regs.svh"

module itf_input_decoder #(
  parameter int unsigned RESUME_CYCLES = `ITF_RESUME_CYCLES
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // contact inputs: five assignable terminals, the fifth reset to the reverse function
  input  wire logic [4:0]        terminalIn,
  input  wire logic              forwardStart,
  // drive status
  input  wire logic              residualFluxStatus,
  input  wire logic              tuningDone,
  input  wire logic              speedBelowStart,
  // decoded controls
  output itf_pkg::itf_ctrl_t     ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [15:0]            funcCode [5];
  logic [7:0]             opModeParam;
  logic [7:0]             accelPatternParam;
  logic [7:0]             controlSystemParam;
  logic [15:0]            torqueLimit1;
  logic [15:0]            torqueLimit2;
  logic [2:0]             ctrlBits;

  wire apbWrite = psel & penable & pwrite;
  wire apbSetup = psel & ~penable;
  wire hitFuncA = paddr == `ITF_ADDR_FUNC_A;
  wire hitFuncB = paddr == `ITF_ADDR_FUNC_B;
  wire hitFuncC = paddr == `ITF_ADDR_FUNC_C;
  wire hitMode  = paddr == `ITF_ADDR_MODE_CFG;
  wire hitTlim1 = paddr == `ITF_ADDR_TLIM1;
  wire hitTlim2 = paddr == `ITF_ADDR_TLIM2;
  wire hitCtrl  = paddr == `ITF_ADDR_CTRL;
  wire hitStat  = paddr == `ITF_ADDR_STATUS;
  wire hitAny   = hitFuncA | hitFuncB | hitFuncC | hitMode | hitTlim1 | hitTlim2
                  | hitCtrl | hitStat;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~hitAny | (pwrite & hitStat));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      funcCode[0]        <= 16'(`ITF_RST_FUNC_A);
      funcCode[1]        <= 16'(`ITF_RST_FUNC_A >> 16);
      funcCode[2]        <= 16'(`ITF_RST_FUNC_B);
      funcCode[3]        <= 16'(`ITF_RST_FUNC_B >> 16);
      funcCode[4]        <= 16'(`ITF_RST_FUNC_C);
      opModeParam        <= 8'h00;
      accelPatternParam  <= 8'h00;
      controlSystemParam <= 8'h00;
      torqueLimit1       <= `ITF_RST_TLIM;
      torqueLimit2       <= `ITF_RST_TLIM;
      ctrlBits           <= 3'h0;
    end else if (apbWrite) begin
      if (hitFuncA) begin
        funcCode[0] <= pwdata[15:0];
        funcCode[1] <= pwdata[31:16];
      end
      if (hitFuncB) begin
        funcCode[2] <= pwdata[15:0];
        funcCode[3] <= pwdata[31:16];
      end
      if (hitFuncC) funcCode[4] <= pwdata[15:0];
      if (hitMode) begin
        opModeParam        <= pwdata[7:0];
        accelPatternParam  <= pwdata[15:8];
        controlSystemParam <= pwdata[23:16];
      end
      if (hitTlim1) torqueLimit1 <= pwdata[15:0];
      if (hitTlim2) torqueLimit2 <= pwdata[15:0];
      if (hitCtrl) ctrlBits <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal decode

  // a function sees the or of the terminals assigned to it, inactive otherwise
  function automatic logic fnLevel(input logic [15:0] code, input logic [4:0] lv,
                                   input logic [15:0] fc0, input logic [15:0] fc1,
                                   input logic [15:0] fc2, input logic [15:0] fc3,
                                   input logic [15:0] fc4);
    fnLevel = (lv[0] & (fc0 == code)) | (lv[1] & (fc1 == code)) | (lv[2] & (fc2 == code))
              | (lv[3] & (fc3 == code)) | (lv[4] & (fc4 == code));
  endfunction

  function automatic logic fnMapped(input logic [15:0] code,
                                    input logic [15:0] fc0, input logic [15:0] fc1,
                                    input logic [15:0] fc2, input logic [15:0] fc3,
                                    input logic [15:0] fc4);
    fnMapped = (fc0 == code) | (fc1 == code) | (fc2 == code) | (fc3 == code) | (fc4 == code);
  endfunction

  `define ITF_LV(c) fnLevel(c, terminalIn, funcCode[0], funcCode[1], funcCode[2], \
                            funcCode[3], funcCode[4])
  `define ITF_MAP(c) fnMapped(c, funcCode[0], funcCode[1], funcCode[2], funcCode[3], \
                              funcCode[4])

  wire secondSel   = `ITF_LV(`ITF_CODE_SECOND);
  wire thirdSel    = `ITF_LV(`ITF_CODE_THIRD);
  wire pidIn       = `ITF_LV(`ITF_CODE_PID);
  wire panelExtIn  = `ITF_LV(`ITF_CODE_PANEL_EXT);
  wire scurveIn    = `ITF_LV(`ITF_CODE_SCURVE);
  wire orientIn    = `ITF_LV(`ITF_CODE_ORIENT);
  wire preexciteIn = `ITF_LV(`ITF_CODE_PREEXCITE);
  wire outStopIn   = `ITF_LV(`ITF_CODE_OUT_STOP);
  wire selfHoldIn  = `ITF_LV(`ITF_CODE_SELF_HOLD);
  wire modeChgIn   = `ITF_LV(`ITF_CODE_MODE_CHG);
  wire tlimSelIn   = `ITF_LV(`ITF_CODE_TLIM_SEL);
  wire tuneIn      = `ITF_LV(`ITF_CODE_TUNE);
  wire biasAIn     = `ITF_LV(`ITF_CODE_BIAS_A);
  wire biasBIn     = `ITF_LV(`ITF_CODE_BIAS_B);
  wire reverseIn   = `ITF_LV(`ITF_CODE_REVERSE);
  // an unassigned enable or interlock must not block the drive
  wire convEnable  = ~`ITF_MAP(`ITF_CODE_CONV_EN) | `ITF_LV(`ITF_CODE_CONV_EN);
  wire panelLockOk = ~`ITF_MAP(`ITF_CODE_PANEL_LOCK) | `ITF_LV(`ITF_CODE_PANEL_LOCK);
  wire selfHoldMap = `ITF_MAP(`ITF_CODE_SELF_HOLD);
  wire panelExtMap = `ITF_MAP(`ITF_CODE_PANEL_EXT);

  `undef ITF_LV
  `undef ITF_MAP

  ////////////////////////////////////////////////////////////////////////////
  // tuning and start qualification

  itf_pkg::itf_tune_state_t tuneState;
  itf_pkg::itf_tune_state_t next_tuneState;
  logic                     tunePrev;

  wire vfControl  = ctrlBits[`ITF_CTRL_VF];
  wire tuneBusy   = tuneState == itf_pkg::ITF_TUNE_BUSY;
  wire rawStart   = forwardStart | reverseIn;
  wire tuneByPin  = tuneIn & ~tunePrev & ~rawStart & ~residualFluxStatus;
  wire tuneByLx   = preexciteIn & rawStart & speedBelowStart;
  wire tuneKick   = ~vfControl & (tuneByPin | tuneByLx);
  // starts and pre-excite are held off until tuning has finished
  wire fwdQual    = forwardStart & ~tuneBusy;
  wire revQual    = reverseIn & ~tuneBusy;
  wire lxQual     = preexciteIn & ~tuneBusy;
  wire tuneDone   = tuningDone;

  always_comb begin
    next_tuneState = tuneState;
    case (tuneState)
      itf_pkg::ITF_TUNE_IDLE: if (tuneKick) next_tuneState = itf_pkg::ITF_TUNE_BUSY;
      itf_pkg::ITF_TUNE_BUSY: if (tuneDone | vfControl) next_tuneState = itf_pkg::ITF_TUNE_IDLE;
      default:                next_tuneState = itf_pkg::ITF_TUNE_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tuneState <= itf_pkg::ITF_TUNE_IDLE;
      tunePrev  <= 1'b0;
    end else begin
      tuneState <= next_tuneState;
      tunePrev  <= tuneIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stop and resume delay

  itf_pkg::itf_out_state_t outState;
  itf_pkg::itf_out_state_t next_outState;
  logic [31:0]             resumeCount;

  wire resumeDone = resumeCount >= RESUME_CYCLES - 1;

  always_comb begin
    next_outState = outState;
    case (outState)
      itf_pkg::ITF_OUT_RUN:      if (outStopIn) next_outState = itf_pkg::ITF_OUT_STOPPED;
      itf_pkg::ITF_OUT_STOPPED:  if (!outStopIn) next_outState = itf_pkg::ITF_OUT_RESUMING;
      itf_pkg::ITF_OUT_RESUMING: begin
        if (outStopIn) next_outState = itf_pkg::ITF_OUT_STOPPED;
        else if (resumeDone) next_outState = itf_pkg::ITF_OUT_RUN;
      end
      default:                   next_outState = itf_pkg::ITF_OUT_STOPPED;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outState    <= itf_pkg::ITF_OUT_RUN;
      resumeCount <= 32'h0;
    end else begin
      outState    <= next_outState;
      resumeCount <= (outState == itf_pkg::ITF_OUT_RESUMING) ? resumeCount + 32'h1 : 32'h0;
    end
  end

  // stop acts in the same cycle the input is seen, in every control mode
  wire outStopped = outStopIn | (outState != itf_pkg::ITF_OUT_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // start self-hold

  logic holdFwd;
  logic holdRev;

  // start together with stop disables rotation in both directions
  wire startConflict = selfHoldMap & ~selfHoldIn & (fwdQual | revQual);
  wire fwdCmd = selfHoldMap ? holdFwd : fwdQual;
  wire revCmd = selfHoldMap ? holdRev : revQual;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      holdFwd <= 1'b0;
      holdRev <= 1'b0;
    end else begin
      holdFwd <= selfHoldIn & ~startConflict & (fwdQual & ~revQual | holdFwd & ~revQual);
      holdRev <= selfHoldIn & ~startConflict & (revQual & ~fwdQual | holdRev & ~fwdQual);
    end
  end

  // a stopped output blocks the run commands; the self-hold latch still takes starts
  wire runFwd = fwdCmd & ~revCmd & ~outStopped & convEnable;
  wire runRev = revCmd & ~fwdCmd & ~outStopped & convEnable;

  ////////////////////////////////////////////////////////////////////////////
  // mode selection

  logic panelMode;

  // param 8 with the switch terminal assigned hands the choice to the pin
  wire wantPanel = (opModeParam == `ITF_OPMODE_SWITCH && panelExtMap) ? ~panelExtIn
                   : ctrlBits[`ITF_CTRL_PANEL_REQ];
  wire next_panelMode = wantPanel ? (panelMode | panelLockOk) : 1'b0;

  wire [3:0] modeNibble = modeChgIn ? controlSystemParam[7:4] : controlSystemParam[3:0];
  wire itf_pkg::itf_ctl_mode_t modeSel =
    (modeNibble == 4'h1) ? itf_pkg::ITF_MODE_TORQUE :
    (modeNibble == 4'h2) ? itf_pkg::ITF_MODE_POSITION : itf_pkg::ITF_MODE_SPEED;

  wire servoOnNow  = lxQual & (modeSel == itf_pkg::ITF_MODE_POSITION) & ~outStopped;
  wire zeroLockNow = lxQual & ~fwdQual & ~revQual & ~outStopped;

  ////////////////////////////////////////////////////////////////////////////
  // registered controls

  itf_pkg::itf_ctrl_t next_ctrl;

  always_comb begin
    next_ctrl                = '0;
    next_ctrl.outputEnable   = convEnable & ~outStopped & (runFwd | runRev | servoOnNow
                                                          | zeroLockNow);
    next_ctrl.secondMotor    = secondSel;
    next_ctrl.functionSet    = thirdSel ? 2'h3 : (secondSel ? 2'h2 : 2'h1);
    next_ctrl.pidEnable      = pidIn;
    next_ctrl.panelOperation = next_panelMode;
    next_ctrl.scurveSet2     = (accelPatternParam == `ITF_ACCEL_SCURVE_C) & scurveIn;
    next_ctrl.orientation    = orientIn & ctrlBits[`ITF_CTRL_ENCODER];
    next_ctrl.zeroSpeedLock  = zeroLockNow;
    next_ctrl.servoOn        = servoOnNow;
    next_ctrl.runForward     = runFwd;
    next_ctrl.runReverse     = runRev;
    next_ctrl.controlMode    = modeSel;
    next_ctrl.torqueLimit    = tlimSelIn ? torqueLimit2 : torqueLimit1;
    next_ctrl.tuningActive   = tuneBusy;
    next_ctrl.torqueBiasSel  = {biasBIn, biasAIn};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= '0;
      panelMode <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      panelMode <= next_panelMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  wire [31:0] statusWord = {12'h0, ctrl.torqueBiasSel, ctrl.controlMode, outState, tuneState,
                            ctrl.functionSet, ctrl.secondMotor, ctrl.pidEnable,
                            ctrl.panelOperation, ctrl.scurveSet2, ctrl.orientation,
                            ctrl.zeroSpeedLock, ctrl.servoOn, ctrl.runForward,
                            ctrl.runReverse, ctrl.outputEnable};

  wire [31:0] readMux =
    hitFuncA ? {funcCode[1], funcCode[0]} :
    hitFuncB ? {funcCode[3], funcCode[2]} :
    hitFuncC ? {16'h0, funcCode[4]} :
    hitMode  ? {8'h0, controlSystemParam, accelPatternParam, opModeParam} :
    hitTlim1 ? {16'h0, torqueLimit1} :
    hitTlim2 ? {16'h0, torqueLimit2} :
    hitCtrl  ? {29'h0, ctrlBits} :
    hitStat  ? statusWord : 32'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h0;
    else if (apbSetup && !pwrite) prdata <= readMux;
  end

endmodule
`default_nettype wire

// ==== logic/itf_pkg.sv ====
// types shared by the input function decoder
package itf_pkg;

  typedef enum logic [1:0] {
    ITF_MODE_SPEED    = 2'h0,
    ITF_MODE_TORQUE   = 2'h1,
    ITF_MODE_POSITION = 2'h2
  } itf_ctl_mode_t;

  // gray along run -> stopped -> resuming; the return from resuming to run changes both bits
  typedef enum logic [1:0] {
    ITF_OUT_RUN      = 2'h0,
    ITF_OUT_STOPPED  = 2'h1,
    ITF_OUT_RESUMING = 2'h3
  } itf_out_state_t;

  typedef enum logic [1:0] {
    ITF_TUNE_IDLE = 2'h0,
    ITF_TUNE_BUSY = 2'h1
  } itf_tune_state_t;

  typedef struct packed {
    logic          outputEnable;
    logic          secondMotor;
    logic [1:0]    functionSet;
    logic          pidEnable;
    logic          panelOperation;
    logic          scurveSet2;
    logic          orientation;
    logic          zeroSpeedLock;
    logic          servoOn;
    logic          runForward;
    logic          runReverse;
    itf_ctl_mode_t controlMode;
    logic [15:0]   torqueLimit;
    logic          tuningActive;
    logic [1:0]    torqueBiasSel;
  } itf_ctrl_t;

endpackage

// ==== logic/itf_regs.svh ====
// register offsets, field positions, reset values and timing for the input function decoder
`ifndef ITF_REGS_SVH
`define ITF_REGS_SVH

`define ITF_ADDR_FUNC_A       8'h00
`define ITF_ADDR_FUNC_B       8'h04
`define ITF_ADDR_FUNC_C       8'h08
`define ITF_ADDR_MODE_CFG     8'h0c
`define ITF_ADDR_TLIM1        8'h10
`define ITF_ADDR_TLIM2        8'h14
`define ITF_ADDR_CTRL         8'h18
`define ITF_ADDR_STATUS       8'h1c

`define ITF_RST_FUNC_A        32'h0001_0000
`define ITF_RST_FUNC_B        32'h0003_0002
`define ITF_RST_FUNC_C        32'h0000_270f
`define ITF_RST_MODE_CFG      32'h0000_0000
`define ITF_RST_TLIM          16'h0096

`define ITF_CTRL_ENCODER      0
`define ITF_CTRL_PANEL_REQ    1
`define ITF_CTRL_VF           2

`define ITF_CODE_SECOND       16'h0003
`define ITF_CODE_THIRD        16'h0009
`define ITF_CODE_CONV_EN      16'h000a
`define ITF_CODE_PANEL_LOCK   16'h000c
`define ITF_CODE_PID          16'h000e
`define ITF_CODE_PANEL_EXT    16'h0010
`define ITF_CODE_SCURVE       16'h0014
`define ITF_CODE_ORIENT       16'h0016
`define ITF_CODE_PREEXCITE    16'h0017
`define ITF_CODE_OUT_STOP     16'h0018
`define ITF_CODE_SELF_HOLD    16'h0019
`define ITF_CODE_MODE_CHG     16'h001a
`define ITF_CODE_TLIM_SEL     16'h001b
`define ITF_CODE_TUNE         16'h001c
`define ITF_CODE_BIAS_A       16'h002a
`define ITF_CODE_BIAS_B       16'h002b
`define ITF_CODE_REVERSE      16'h270f

`define ITF_OPMODE_SWITCH     8'h08
`define ITF_ACCEL_SCURVE_C    8'h04

`define ITF_CLK_HZ            10000000
`define ITF_RESUME_MS         20
`define ITF_RESUME_CYCLES     ((`ITF_CLK_HZ / 1000) * `ITF_RESUME_MS)

`endif

// ==== tb/input_terminal_function_decoder_tb.sv ====
// self-checking bench for the input function decoder
`timescale 1ns/1ns
`default_nettype none
`include "itf_regs.svh"
module input_terminal_function_decoder_tb;
  localparam int unsigned RES = 8;
  logic               clock, rst_n, psel, penable, pwrite, pready, pslverr, errv;
  logic               wantFwd, brakeOn, forwardStart, residualFluxStatus, tuningDone;
  logic               speedBelowStart;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rdv;
  logic [4:0]         want, terminalIn;
  logic [1:0]         lv;
  logic [15:0]        tl2;
  itf_pkg::itf_ctrl_t ctrl;
  int                 err_count, total_checks, cycles, n;
  logic [31:0] rstTab [7] = '{`ITF_RST_FUNC_A, `ITF_RST_FUNC_B, `ITF_RST_FUNC_C,
    `ITF_RST_MODE_CFG, 32'(`ITF_RST_TLIM), 32'(`ITF_RST_TLIM), 32'h0};
  int          simpleCodes [4] = '{20, 22, 23, 16};
  logic [31:0] cfgTab [3] = '{32'h0003_0009, 32'h002b_002a, 32'h001b_000e};

  itf_input_decoder #(.RESUME_CYCLES(RES)) itf_input_decoder_i (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .terminalIn(terminalIn), .forwardStart(forwardStart),
    .residualFluxStatus(residualFluxStatus), .tuningDone(tuningDone),
    .speedBelowStart(speedBelowStart), .ctrl(ctrl));
  itf_contact_model itf_contact_model_i (.clock(clock), .rst_n(rst_n), .want(want),
    .wantFwd(wantFwd), .brakeOn(brakeOn), .terminalIn(terminalIn), .forwardStart(forwardStart));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer; a leading edge keeps back-to-back calls off the same time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // pready high ends this wait; the bench timeout catches a slave that never answers
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // contact model and ctrl register take an edge each; the tuning state one more
  task automatic settle;
    repeat (4) @(posedge clock);
  endtask
  function automatic logic [31:0] gotOf(input int k);
    case (k)
      0: return 32'({ctrl.functionSet, ctrl.secondMotor});
      1: return 32'(ctrl.torqueBiasSel);
      default: return {ctrl.torqueLimit, 15'h0, ctrl.pidEnable};
    endcase
  endfunction
  // DI3 is v[0], DI4 is v[1]
  function automatic logic [31:0] expOf(input int k, input logic [1:0] v, input logic [15:0] t2);
    case (k)
      0: return 32'({v[0] ? 2'h3 : (v[1] ? 2'h2 : 2'h1), v[1]});
      1: return 32'(v);
      default: return {v[1] ? t2 : `ITF_RST_TLIM, 15'h0, v[0]};
    endcase
  endfunction
  function automatic logic fieldOf(input int c);
    case (c)
      20: return ctrl.scurveSet2;
      22: return ctrl.orientation;
      23: return ctrl.zeroSpeedLock;
      default: return ctrl.panelOperation;
    endcase
  endfunction
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // run far beyond the expected few hundred cycles means a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 5'h00;
    wantFwd = 1'b0;
    brakeOn = 1'b0;
    residualFluxStatus = 1'b0;
    tuningDone = 1'b0;
    speedBelowStart = 1'b0;
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(32'hf4ad));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rstTab[i]) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rdv, rstTab[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({rdv[30:0], errv}, 32'h1);
    apb(1'b1, `ITF_ADDR_STATUS, 32'hffff_ffff);
    chk(32'(errv), 32'h1);
    $display("test registers done");
    apb(1'b1, `ITF_ADDR_FUNC_B, 32'h0003_0018);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `ITF_ADDR_MODE_CFG, 32'(m) << 16);
      wantFwd <= 1'b1;
      settle();
      chk(32'(ctrl.outputEnable), 32'h1);
      chk(32'(ctrl.controlMode), 32'(m));
      brakeOn <= 1'b1;
      settle();
      chk(32'({ctrl.outputEnable, ctrl.runForward}), 32'h0);
      brakeOn <= 1'b0;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (ctrl.outputEnable !== 1'b1 && n < 60);
      chk(32'(n >= RES && n <= RES + 6), 32'h1);
      wantFwd <= 1'b0;
    end
    // mode-change terminal on DI2 picks the high nibble: torque normally, position when on
    apb(1'b1, `ITF_ADDR_FUNC_A, 32'h001a_0000);
    apb(1'b1, `ITF_ADDR_MODE_CFG, 32'h0021_0000);
    want <= 5'h02;
    settle();
    chk(32'(ctrl.controlMode), 32'h2);
    $display("test output stop done");
    foreach (cfgTab[k]) begin
      apb(1'b1, `ITF_ADDR_FUNC_B, cfgTab[k]);
      tl2 = 16'($urandom);
      apb(1'b1, `ITF_ADDR_TLIM2, 32'(tl2));
      for (int i = 0; i < 8; i++) begin
        lv = (i < 4) ? 2'(i) : 2'($urandom);
        want <= {2'h0, lv, 2'h0};
        settle();
        chk(gotOf(k), expOf(k, lv, tl2));
      end
    end
    $display("test paired terminals done");
    apb(1'b1, `ITF_ADDR_MODE_CFG, 32'h0000_0408);
    apb(1'b1, `ITF_ADDR_CTRL, 32'h1);
    foreach (simpleCodes[c]) begin
      apb(1'b1, `ITF_ADDR_FUNC_B, 32'(simpleCodes[c]));
      for (int i = 0; i < 4; i++) begin
        lv = {1'b0, i[0] ^ 1'($urandom)};
        want <= {2'h0, lv, 2'h0};
        settle();
        chk(32'(fieldOf(simpleCodes[c])), 32'(lv[0] ^ (c == 3)));
        chk(32'(ctrl.pidEnable), 32'h0);
      end
    end
    apb(1'b1, `ITF_ADDR_FUNC_B, 32'h000c_0010);
    want <= 5'h04;
    settle();
    want <= 5'h00;
    settle();
    chk(32'(ctrl.panelOperation), 32'h0);
    want <= 5'h0c;
    settle();
    want <= 5'h08;
    settle();
    chk(32'(ctrl.panelOperation), 32'h1);
    $display("test single functions done");
    // tuning pin on DI3, pre-excite on DI4
    apb(1'b1, `ITF_ADDR_FUNC_B, 32'h0017_001c);
    residualFluxStatus <= 1'b1;
    want <= 5'h04;
    settle();
    chk(32'(ctrl.tuningActive), 32'h0);
    residualFluxStatus <= 1'b0;
    want <= 5'h00;
    settle();
    want <= 5'h04;
    settle();
    wantFwd <= 1'b1;
    settle();
    chk(32'({ctrl.tuningActive, ctrl.runForward}), 32'h2);
    tuningDone <= 1'b1;
    settle();
    chk(32'({ctrl.tuningActive, ctrl.runForward}), 32'h1);
    tuningDone <= 1'b0;
    speedBelowStart <= 1'b1;
    want <= 5'h08;
    settle();
    chk(32'(ctrl.tuningActive), 32'h1);
    apb(1'b1, `ITF_ADDR_CTRL, 32'h5);
    settle();
    chk(32'(ctrl.tuningActive), 32'h0);
    apb(1'b1, `ITF_ADDR_MODE_CFG, 32'h0002_0408);
    settle();
    chk(32'(ctrl.servoOn), 32'h1);
    $display("test tuning done");
    conclude();
  end
endmodule
`default_nettype wire

// ==== tb/itf_contact_model.sv ====
// external contacts: switch levels plus a brake that holds the stop contact
`timescale 1ns/1ns
`default_nettype none
module itf_contact_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // requested states
  input  wire logic [4:0] want,
  input  wire logic       wantFwd,
  input  wire logic       brakeOn,
  // contacts toward the drive
  output logic [4:0]      terminalIn,
  output logic            forwardStart
);
  // stop contact lives on DI3; it drops with the brake, before any restart
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      terminalIn   <= 5'h00;
      forwardStart <= 1'b0;
    end else begin
      terminalIn   <= want | {2'h0, brakeOn, 2'h0};
      forwardStart <= wantFwd;
    end
  end
endmodule
`default_nettype wire

// ==== tb/itf_decoder_asserts.sv ====
// concurrent checks on the input function decoder ports
`timescale 1ns/1ns
`default_nettype none
`include "itf_regs.svh"
module itf_decoder_asserts #(
  parameter int unsigned RESUME_CYCLES = 8
) (
  // clock and reset
  input wire logic               clock,
  input wire logic               rst_n,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // terminals and decoded controls
  input wire logic [4:0]         terminalIn,
  input wire logic               forwardStart,
  input wire itf_pkg::itf_ctrl_t ctrl
);
  // mirror of DI3/DI4 codes and the second limit; repetition counts assume RESUME_CYCLES 8
  logic [31:0] cfgB;
  logic [15:0] tlim2;
  wire         wrEn   = psel && penable && pwrite && pready;
  wire         stopOn = cfgB[15:0] == `ITF_CODE_OUT_STOP && terminalIn[2];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgB  <= `ITF_RST_FUNC_B;
      tlim2 <= `ITF_RST_TLIM;
    end else if (wrEn && paddr == `ITF_ADDR_FUNC_B) begin
      cfgB <= pwdata;
    end else if (wrEn && paddr == `ITF_ADDR_TLIM2) begin
      tlim2 <= pwdata[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence stopReleased;
    $fell(stopOn);
  endsequence
  // start must stand through the resume delay and both register stages
  sequence startHeld;
    (forwardStart && !stopOn && !ctrl.tuningActive) [*8]
    ##1 (forwardStart && !stopOn && !ctrl.tuningActive) [*2];
  endsequence
  unmapped_err_a: assert property (psel && penable && paddr > `ITF_ADDR_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  stop_cut_a: assert property (stopOn |=> !ctrl.outputEnable)
    else $error("output not cut by stop input");
  stop_blocks_a: assert property (stopOn && forwardStart |=> !ctrl.runForward)
    else $error("start passed during stop");
  resume_late_a: assert property (stopReleased |-> !ctrl.outputEnable [*4])
    else $error("output resumed too early");
  resume_soon_a: assert property (
    stopReleased ##0 startHeld |-> ##[1:3] ctrl.outputEnable)
    else $error("output did not resume");
  pid_follow_a: assert property (
    cfgB[15:0] == `ITF_CODE_PID |=> ctrl.pidEnable == $past(terminalIn[2]))
    else $error("pid enable not following input");
  third_set_a: assert property (
    cfgB == {`ITF_CODE_SECOND, `ITF_CODE_THIRD} && terminalIn[2]
    |=> ctrl.functionSet == 2'h3 && ctrl.secondMotor == $past(terminalIn[3]))
    else $error("third set wrong");
  second_set_a: assert property (
    cfgB == {`ITF_CODE_SECOND, `ITF_CODE_THIRD} && !terminalIn[2]
    |=> ctrl.functionSet == ($past(terminalIn[3]) ? 2'h2 : 2'h1))
    else $error("first or second set wrong");
  bias_pair_a: assert property (
    cfgB == {`ITF_CODE_BIAS_B, `ITF_CODE_BIAS_A}
    |=> ctrl.torqueBiasSel == $past(terminalIn[3:2]))
    else $error("torque bias pair wrong");
  tlim_sel_a: assert property (
    cfgB[31:16] == `ITF_CODE_TLIM_SEL && terminalIn[3]
    |=> ctrl.torqueLimit == $past(tlim2))
    else $error("second torque limit not applied");
endmodule
bind itf_input_decoder itf_decoder_asserts #(.RESUME_CYCLES(RESUME_CYCLES)) itf_decoder_asserts_i (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .terminalIn(terminalIn), .forwardStart(forwardStart), .ctrl(ctrl));
`default_nettype wire
